// ==== hw/temp_sensor_serial_port.sv ====
/*
 * Slave serial port and conversion sequencer of the temperature sensor.
 * Assumes the select, serial clock and serial input pins are
 * asynchronous to sys_clk and that the clock is at least four times
 * slower than sys_clk; temp_code is the converter output on sys_clk.
 */
`timescale 1ns/1ps
module temp_sensor_serial_port #(
  parameter int CONV_PERIOD = temp_sensor_pkg::CONV_PERIOD_CYC,
  parameter int CONV_TIME = temp_sensor_pkg::CONV_TIME_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic [9:0] temp_code,
  output logic dout,
  output logic dout_oe,
  output logic shutdown,
  output logic converting
);

  localparam logic [15:0] RUN_LAST = 16'(CONV_TIME - 1);
  localparam logic [15:0] WAIT_LAST = 16'(CONV_PERIOD - CONV_TIME - 1);

  temp_sensor_pkg::port_state_t st;
  temp_sensor_pkg::port_state_t next_st;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;

  // ****************************************************************
  // Edge detection on synchronised pins
  // ****************************************************************
  // Only stages one and two are examined; stage zero feeds stage one
  assign cs_low = ~st.cs_sync[1];
  assign cs_fall = st.cs_sync[2] & ~st.cs_sync[1];
  assign cs_rise = ~st.cs_sync[2] & st.cs_sync[1];
  assign sclk_fall = cs_low & st.sclk_sync[2] & ~st.sclk_sync[1];
  assign sclk_rise = cs_low & ~st.sclk_sync[2] & st.sclk_sync[1];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.sclk_sync = {st.sclk_sync[1:0], sclk};
    next_st.cs_sync = {st.cs_sync[1:0], cs_n};
    next_st.din_sync = {st.din_sync[0], din};

    // Frame start: capture result, zero padding behind it
    if (cs_fall) begin
      next_st.tx = {st.result, temp_sensor_pkg::PAD_ZEROS};
      next_st.fall_cnt = '0;
      next_st.rise_cnt = '0;
      next_st.dout_oe = 1'b1;
    end

    // Output changes only on falling clock edges, MSB first
    if (sclk_fall && st.fall_cnt != temp_sensor_pkg::FRAME_END) begin
      next_st.dout = st.tx[15];
      next_st.tx = {st.tx[14:0], 1'b0};
      next_st.fall_cnt = st.fall_cnt + 5'h01;
      // Fifteenth falling edge commits the control word
      if (st.fall_cnt == temp_sensor_pkg::LOAD_FALL_IDX) begin
        next_st.control = st.rx;
        next_st.shutdown = st.pd_bit;
        if (st.pd_bit) begin
          next_st.phase = temp_sensor_pkg::CONV_OFF;
        end else if (st.shutdown) begin
          // Waking restarts the conversion at once
          next_st.phase = temp_sensor_pkg::CONV_RUN;
          next_st.timer = '0;
        end
      end
    end

    // Input sampled on rising edges, in the same frame
    if (sclk_rise && st.rise_cnt != temp_sensor_pkg::FRAME_END) begin
      next_st.rx = {st.rx[14:0], st.din_sync[1]};
      next_st.rise_cnt = st.rise_cnt + 5'h01;
      if (st.rise_cnt == temp_sensor_pkg::PD_RISE_IDX) begin
        next_st.pd_bit = st.din_sync[1];
      end
    end

    // Select high releases the line; an early rise loads nothing
    if (!cs_low) begin
      next_st.dout_oe = 1'b0;
    end

    // Conversion sequencer; result only moves at conversion end
    unique case (st.phase)
      temp_sensor_pkg::CONV_OFF: begin
        // Parked at zero so a wake always runs a full conversion
        next_st.timer = '0;
      end
      temp_sensor_pkg::CONV_WAIT: begin
        if (st.timer == WAIT_LAST) begin
          next_st.phase = temp_sensor_pkg::CONV_RUN;
          next_st.timer = '0;
        end else begin
          next_st.timer = st.timer + 16'h0001;
        end
      end
      temp_sensor_pkg::CONV_RUN: begin
        if (st.timer == RUN_LAST) begin
          next_st.result = temp_code;
          next_st.phase = temp_sensor_pkg::CONV_WAIT;
          next_st.timer = '0;
        end else begin
          next_st.timer = st.timer + 16'h0001;
        end
      end
    endcase

    // End of an access restarts the oscillator unless shut down
    if (cs_rise && !st.shutdown) begin
      next_st.phase = temp_sensor_pkg::CONV_RUN;
      next_st.timer = '0;
    end
    // The commit edge wins over the sequencer's own step
    if (sclk_fall && st.fall_cnt == temp_sensor_pkg::LOAD_FALL_IDX
        && st.pd_bit) begin
      next_st.phase = temp_sensor_pkg::CONV_OFF;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.sclk_sync <= 3'h7;
      st.cs_sync <= 3'h7;
      st.control <= temp_sensor_pkg::CONTROL_RESET;
      st.result <= temp_sensor_pkg::RESULT_RESET;
      st.phase <= temp_sensor_pkg::CONV_RUN;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign dout = st.dout;
  assign dout_oe = st.dout_oe;
  assign shutdown = st.shutdown;
  assign converting = st.phase[2];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Result register only moves at a conversion end
  a_result_hold: assert property ($changed(st.result) |->
    $past(st.phase == temp_sensor_pkg::CONV_RUN && st.timer == RUN_LAST))
    else $error("result changed outside conversion end");
  // Select gates the serial clock and the output enable
  a_clock_gated: assert property (!cs_low |=>
    $stable(st.fall_cnt) && $stable(st.rise_cnt))
    else $error("edge counted while deselected");
  a_release_line: assert property (!cs_low |=> !dout_oe)
    else $error("output driven while deselected");
  // Control commits on the fifteenth fall, nothing on an abort
  a_load_fifteenth: assert property (sclk_fall &&
    st.fall_cnt == temp_sensor_pkg::LOAD_FALL_IDX |=>
    st.control == $past(st.rx) && shutdown == $past(st.pd_bit))
    else $error("control not loaded at fifteenth fall");
  a_abort_keeps: assert property (cs_rise &&
    st.fall_cnt <= temp_sensor_pkg::LOAD_FALL_IDX |=>
    $stable(shutdown) && $stable(st.control))
    else $error("aborted frame changed control");
  a_shutdown_hold: assert property (!(sclk_fall &&
    st.fall_cnt == temp_sensor_pkg::LOAD_FALL_IDX) |=> $stable(shutdown))
    else $error("shutdown moved off the commit edge");
  // Output ordering: result leads, padding follows
  a_frame_load: assert property (cs_fall && !sclk_fall |=>
    dout_oe &&
    st.tx == {$past(st.result), temp_sensor_pkg::PAD_ZEROS})
    else $error("frame start did not load the result");
  a_msb_first: assert property (sclk_fall && st.fall_cnt == 5'h00 |=>
    dout == $past(st.tx[15]) && st.tx[15:1] == $past(st.tx[14:0]))
    else $error("first bit is not result msb");
  a_pad_zero: assert property (sclk_fall &&
    st.fall_cnt == 5'h0b |=> !dout)
    else $error("padding bit not zero");
  // Sequencer follows the shutdown state and the access ends
  a_off_idle: assert property (shutdown |-> !converting)
    else $error("conversion while shut down");
  a_restart_end: assert property (cs_rise && !shutdown &&
    !sclk_fall |=> converting && st.timer == 16'h0000)
    else $error("access end did not restart conversion");
  a_wake_restart: assert property (sclk_fall && !st.pd_bit &&
    st.fall_cnt == temp_sensor_pkg::LOAD_FALL_IDX && shutdown |=>
    converting && st.timer == 16'h0000)
    else $error("wake did not restart conversion");
  // Input capture on rising edges, output moves on falling ones
  a_pd_third: assert property (sclk_rise &&
    st.rise_cnt == temp_sensor_pkg::PD_RISE_IDX |=>
    st.pd_bit == $past(st.din_sync[1]))
    else $error("third input bit not captured");
  a_dout_falling: assert property ($changed(dout) |-> $past(sclk_fall))
    else $error("output changed off a falling edge");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  // Full frame, shutdown entry and exit, abort, conversion end
  c_full_frame: cover property (sclk_fall &&
    st.fall_cnt == 5'h0f);
  c_enter_off: cover property ($rose(shutdown));
  c_wake: cover property ($fell(shutdown));
  c_abort: cover property (cs_rise && st.fall_cnt == 5'h0e);
  c_conv_done: cover property ($changed(st.result));

endmodule // temp_sensor_serial_port

// ==== common/temp_sensor_pkg.sv ====
/*
 * Constants, state encodings and the packed state record of the
 * temperature sensor serial port.
 * Assumes one 125 MHz system clock; all link pins arrive asynchronous.
 */
// Overview of operation
// - Read-only ten-bit two's-complement result register
// - Code steps quarter degrees, -128 to +127
// - Device is slave; host supplies clock
// - Clock ignored while select is high
// - Frame shifts result out, control in
// - Frame is sixteen serial clock pulses
// - Output holds last bit, then released
// - Input sampled on rising clock edges
// - Third received bit requests shutdown
// - Control loads on fifteenth falling edge
// - Early select rise leaves control unchanged
// - Most significant result bit goes first
// - Output changes on falling clock edges
// - Conversion every 400 us, 25 us long
// - Shutdown stops conversions, keeps last result
// - Access end or wake restarts conversion
package temp_sensor_pkg;

  // ****************************************************************
  // Frame and field layout
  // ****************************************************************
  localparam int RESULT_W = 10;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] PD_RISE_IDX = 5'h02; // rises before third
  localparam logic [4:0] LOAD_FALL_IDX = 5'h0e; // falls before 15th
  localparam logic [4:0] FRAME_END = 5'h10;
  localparam logic [5:0] PAD_ZEROS = 6'h00;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CONV_PERIOD_US = 400;
  localparam int CONV_TIME_US = 25;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int CONV_TIME_CYC = CONV_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int TIMER_W = 16;

  // ****************************************************************
  // Converter sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    CONV_OFF = 3'b001,
    CONV_WAIT = 3'b010,
    CONV_RUN = 3'b100
  } conv_state_t;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] din_sync;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic pd_bit;
    logic [15:0] control;
    logic [9:0] result;
    logic shutdown;
    logic dout;
    logic dout_oe;
    conv_state_t phase;
    logic [15:0] timer;
  } port_state_t;

endpackage

// ==== tb/host_master.sv ====
/*
 * Behavioural serial master that stands in for the host controller.
 * Assumes the bench resolves nothing else on the data line.
 */
`timescale 1ns/1ps
module host_master (
  input wire logic sys_clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // ****************************************************************
  // Line model and frame tasks
  // ****************************************************************
  logic line;
  logic [1:0] tail;
  // Idle levels: clock high, input low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    tail = 2'h0;
  end
  // A released line shows the inverse of the last bit, never a stale bit
  assign line = dout_oe ? dout : ~dout;
  // Host supplies every clock; nf below 15 aborts the frame
  task automatic frame(input logic [15:0] w, input int nf,
                       input bit split, output logic [15:0] r);
    r = 16'h0000;
    // Quarter ns off the grid, so no pin ever moves on a clock edge
    @(negedge sys_clk);
    #0.25;
    cs_n = 1'b0;
    #100;
    for (int k = 0; k < 16; k++) begin
      if (k < nf) begin
        sclk = 1'b0;
        din = w[15-k];
        #62.5;
        sclk = 1'b1;
        r[15-k] = line;
        #62.5;
        if (split && k == 7) #300;
      end
    end
    #100;
    tail = {dout_oe, line};
    cs_n = 1'b1;
    din = 1'b0;
    #120;
  endtask
  // Clock pulses while deselected
  task automatic noise(input int n);
    @(negedge sys_clk);
    #0.25;
    din = 1'b1;
    repeat (n) begin
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    din = 1'b0;
  endtask
endmodule // host_master

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the temperature sensor serial port.
 * Assumes host_master drives the link; short conversion counts.
 */
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Bench body
  // ****************************************************************
  localparam int PER = 200;
  localparam int TIM = 20;
  localparam logic [39:0] CORNERS = {10'h200, 10'h3ff, 10'h001, 10'h1fc};
  logic sys_clk, reset, cs_n, sclk, din, dout, dout_oe;
  logic shutdown, converting;
  logic [9:0] temp_code, held;
  logic [15:0] r;
  int failures, n_tests;
  temp_sensor_serial_port #(.CONV_PERIOD(PER), .CONV_TIME(TIM)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .din(din), .temp_code(temp_code), .dout(dout), .dout_oe(dout_oe),
    .shutdown(shutdown), .converting(converting));
  host_master host (.sys_clk(sys_clk), .dout(dout), .dout_oe(dout_oe),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Result leads the frame, zero pad after it
  function automatic logic [15:0] exp_frame(input logic [9:0] t);
    return {t, temp_sensor_pkg::PAD_ZEROS};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Longer than one period, so a periodic conversion must land
  task automatic settle(input logic [9:0] t);
    @(negedge sys_clk);
    temp_code = t;
    repeat (PER + 20) @(negedge sys_clk);
  endtask
  initial begin
    #200000;
    failures++;
    complete_run();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    reset = 1'b1;
    temp_code = 10'h000;
    void'($urandom(91951));
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    // Corner codes, then random codes, some frames split in bytes
    for (int i = 0; i < 8; i++) begin
      held = (i < 4) ? CORNERS[i*10 +: 10] : 10'($urandom);
      settle(held);
      host.frame(16'h0000, 16, i[0], r);
      check(r, exp_frame(held));
      check(host.tail, 2'h2);
      check(dout_oe, 1'b0);
      check(converting, 1'b1);
    end
    // Power down with don't-care leading bits set
    host.frame(16'he000, 16, 0, r);
    check(shutdown, 1'b1);
    check(converting, 1'b0);
    settle(~held);
    host.frame(16'h2000, 16, 0, r);
    check(r, exp_frame(held));
    // Aborted wake request leaves shutdown standing
    host.frame(16'h0000, 14, 0, r);
    check(shutdown, 1'b1);
    host.noise(5);
    check(shutdown, 1'b1);
    host.frame(16'h0000, 16, 0, r);
    check(r, exp_frame(held));
    check(shutdown, 1'b0);
    held = ~held;
    settle(held);
    host.frame(16'h0000, 16, 0, r);
    check(r, exp_frame(held));
    complete_run();
  end
endmodule // testbench
